//--- verilog/roa_pkg.sv
package roa_pkg;
    // Instruction and data widths
    localparam int INSN_W = 16;
    localparam int DATA_W = 32;
    localparam int ACC_W = 42;
    localparam int IMM_W = 8;
    localparam int REG_CNT = 16;
    // Field positions of the 16-bit word and the trap offset shift
    localparam int OPC_LSB = 12;
    localparam int RN_LSB = 8;
    localparam int RM_LSB = 4;
    localparam int DISP_LSB = 0;
    localparam int TRAP_SHIFT = 2;
    // Latencies in cycles
    localparam int MUL_LAT = 2;
    localparam int MAC_LAT = 3;
    // Reset values
    localparam logic [31:0] PC_RST = 32'h0000_0000;
    localparam logic [31:0] REG_RST = 32'h0000_0000;
    localparam logic [41:0] ACC_RST = 42'h000_0000_0000;

    // Operation codes after decode
    typedef enum logic [4:0] {
        ROA_NOP = 5'h00,
        ROA_MOV_IMM = 5'h01,
        ROA_ADD_IMM = 5'h02,
        ROA_CMPEQ_IMM = 5'h03,
        ROA_TST_IMM = 5'h04,
        ROA_AND_IMM = 5'h05,
        ROA_OR_IMM = 5'h06,
        ROA_XOR_IMM = 5'h07,
        ROA_TRAP = 5'h08,
        ROA_ADD = 5'h09,
        ROA_CMPGE = 5'h0a,
        ROA_TST = 5'h0b,
        ROA_BT = 5'h0c,
        ROA_BF = 5'h0d,
        ROA_BRA = 5'h0e,
        ROA_LD_PCW = 5'h0f,
        ROA_LD_PCL = 5'h10,
        ROA_LD_IND = 5'h11,
        ROA_LD_POST = 5'h12,
        ROA_ST_PRE = 5'h13,
        ROA_LD_IDX = 5'h14,
        ROA_MUL = 5'h15,
        ROA_MAC = 5'h16,
        ROA_AND_MEM = 5'h17,
        ROA_MOV_REG = 5'h18
    } roa_op_e;

    // Access size
    typedef enum logic [1:0] {
        ROA_SZ_B = 2'h0,
        ROA_SZ_W = 2'h1,
        ROA_SZ_L = 2'h2
    } roa_size_e;

    // Decoded instruction
    typedef struct packed {
        roa_op_e op;
        roa_size_e size;
        logic [3:0] rn;
        logic [3:0] rm;
        logic [31:0] imm;
    } roa_dec_s;

    // Memory request towards the bus interface
    typedef struct packed {
        logic valid;
        logic write;
        roa_size_e size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } roa_mem_s;

    // Size in bytes of an access
    function automatic logic [31:0] size_bytes(input roa_size_e sz);
        case (sz)
            ROA_SZ_B: size_bytes = 32'h0000_0001;
            ROA_SZ_W: size_bytes = 32'h0000_0002;
            default: size_bytes = 32'h0000_0004;
        endcase
    endfunction

    // Sign extension of memory data to a long word
    function automatic logic [31:0] sext_mem(input logic [31:0] d, input roa_size_e sz);
        case (sz)
            ROA_SZ_B: sext_mem = {{24{d[7]}}, d[7:0]};
            ROA_SZ_W: sext_mem = {{16{d[15]}}, d[15:0]};
            default: sext_mem = d;
        endcase
    endfunction
endpackage

//--- verilog/roa_decoder.sv
`timescale 1ns/1ps
module roa_decoder (
    input wire logic [15:0] insn_i,
    output roa_pkg::roa_dec_s dec_o
);
    logic [7:0] imm8;
    logic [3:0] opc;
    logic [3:0] sub;
    assign imm8 = insn_i[7:0];
    assign opc = insn_i[roa_pkg::OPC_LSB +: 4];
    assign sub = insn_i[3:0];

    // Field split and immediate extension
    always_comb
    begin
        dec_o = '0;
        dec_o.rn = insn_i[roa_pkg::RN_LSB +: 4];
        dec_o.rm = insn_i[roa_pkg::RM_LSB +: 4];
        dec_o.size = roa_pkg::ROA_SZ_L;
        dec_o.op = roa_pkg::ROA_NOP;
        case (opc)
            4'h0:
            begin
                dec_o.op = sub[2] ? roa_pkg::ROA_LD_IDX : roa_pkg::ROA_NOP;
                dec_o.size = roa_pkg::roa_size_e'(sub[1:0]);
            end
            4'h2:
            begin
                case (sub)
                    4'h8: dec_o.op = roa_pkg::ROA_TST;
                    4'hf: dec_o.op = roa_pkg::ROA_MUL;
                    default:
                    begin
                        dec_o.op = roa_pkg::ROA_ST_PRE;
                        dec_o.size = roa_pkg::roa_size_e'(sub[1:0]);
                    end
                endcase
            end
            4'h3: dec_o.op = (sub == 4'h3) ? roa_pkg::ROA_CMPGE : roa_pkg::ROA_ADD;
            4'h4: dec_o.op = roa_pkg::ROA_MAC;
            4'h6:
            begin
                dec_o.size = roa_pkg::roa_size_e'(sub[1:0]);
                if (sub[2])
                    dec_o.op = roa_pkg::ROA_LD_POST;
                else if (sub[1:0] == 2'h3)
                    dec_o.op = roa_pkg::ROA_MOV_REG;
                else
                    dec_o.op = roa_pkg::ROA_LD_IND;
            end
            4'h7:
            begin
                dec_o.op = roa_pkg::ROA_ADD_IMM;
                dec_o.imm = {{24{imm8[7]}}, imm8};
            end
            4'h8:
            begin
                case (insn_i[11:8])
                    4'h8: dec_o.op = roa_pkg::ROA_CMPEQ_IMM;
                    4'h9: dec_o.op = roa_pkg::ROA_BT;
                    default: dec_o.op = roa_pkg::ROA_BF;
                endcase
                dec_o.imm = {{24{imm8[7]}}, imm8};
            end
            4'h9:
            begin
                dec_o.op = roa_pkg::ROA_LD_PCW;
                dec_o.size = roa_pkg::ROA_SZ_W;
                dec_o.imm = {24'h00_0000, imm8} << 1;
            end
            4'ha:
            begin
                dec_o.op = roa_pkg::ROA_BRA;
                dec_o.imm = {{20{insn_i[11]}}, insn_i[11:0]} << 1;
            end
            4'hc:
            begin
                case (insn_i[11:8])
                    4'h3: dec_o.op = roa_pkg::ROA_TRAP;
                    4'h8: dec_o.op = roa_pkg::ROA_TST_IMM;
                    4'h9: dec_o.op = roa_pkg::ROA_AND_IMM;
                    4'ha: dec_o.op = roa_pkg::ROA_XOR_IMM;
                    4'hd: dec_o.op = roa_pkg::ROA_AND_MEM;
                    default: dec_o.op = roa_pkg::ROA_OR_IMM;
                endcase
                dec_o.size = (insn_i[11:8] == 4'hd) ? roa_pkg::ROA_SZ_B : roa_pkg::ROA_SZ_L;
                if (insn_i[11:8] == 4'h3)
                    dec_o.imm = {24'h00_0000, imm8} << roa_pkg::TRAP_SHIFT;
                else
                    dec_o.imm = {24'h00_0000, imm8};
            end
            4'hd:
            begin
                dec_o.op = roa_pkg::ROA_LD_PCL;
                dec_o.imm = {24'h00_0000, imm8} << 2;
            end
            4'he:
            begin
                dec_o.op = roa_pkg::ROA_MOV_IMM;
                dec_o.imm = {{24{imm8[7]}}, imm8};
            end
            default: dec_o.op = roa_pkg::ROA_NOP;
        endcase
    end
endmodule // roa_decoder

//--- verilog/roa_multiplier.sv
`timescale 1ns/1ps
module roa_multiplier (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire logic acc_i,
    input wire logic [15:0] a_i,
    input wire logic [15:0] b_i,
    input wire logic [41:0] acc_in_i,
    output logic done_o,
    output logic [41:0] result_o
);
    logic [31:0] prod_r;
    logic [41:0] sum_r;
    logic [1:0] cnt_r;
    logic acc_r;
    logic busy_r;

    // Signed product, staged over the latency counter
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            prod_r <= 32'h0000_0000;
            cnt_r <= 2'h0;
            acc_r <= 1'b0;
            busy_r <= 1'b0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (start_i && !busy_r)
            begin
                prod_r <= $signed(a_i) * $signed(b_i);
                acc_r <= acc_i;
                busy_r <= 1'b1;
                cnt_r <= acc_i ? 2'(roa_pkg::MAC_LAT - 1) : 2'(roa_pkg::MUL_LAT - 1);
            end
            else if (busy_r)
            begin
                if (cnt_r == 2'h1)
                begin
                    busy_r <= 1'b0;
                    done_o <= 1'b1;
                end
                cnt_r <= cnt_r - 2'h1;
            end
        end
    end

    // Accumulate into 42 bits for MAC, load the product for MUL
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            sum_r <= roa_pkg::ACC_RST;
        else if (busy_r)
            sum_r <= acc_r ? acc_in_i + {{10{prod_r[31]}}, prod_r}
                           : {{10{prod_r[31]}}, prod_r};
    end
    assign result_o = sum_r;
endmodule // roa_multiplier

//--- verilog/roa_core.sv
`timescale 1ns/1ps
module roa_core (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] insn_i,
    input wire logic insn_valid_i,
    input wire logic mem_ack_i,
    input wire logic [31:0] mem_rdata_i,
    output logic insn_ready_o,
    output logic [31:0] pc_o,
    output roa_pkg::roa_mem_s mem_o,
    output logic flag_o,
    output logic trap_o,
    output logic [31:0] trap_offset_o,
    output logic [41:0] acc_o
);
    typedef enum logic [2:0] {
        ROA_ST_EXEC = 3'b000,
        ROA_ST_MEM = 3'b001,
        ROA_ST_WB = 3'b011,
        ROA_ST_MUL = 3'b010,
        ROA_ST_RMW = 3'b110
    } roa_state_e;

    roa_state_e state_r;
    roa_state_e state_nxt;
    logic [31:0] regs_r [roa_pkg::REG_CNT];
    roa_pkg::roa_dec_s dec;
    roa_pkg::roa_dec_s cur_r;
    logic [31:0] rn_val;
    logic [31:0] rm_val;
    logic [31:0] step;
    logic [31:0] br_target_r;
    logic br_pend_r;
    logic mul_done;
    logic [41:0] mul_res;
    logic fire;
    logic is_mul;
    logic is_mem;

    // Fixed 16-bit word decoder
    roa_decoder u_dec (
        .insn_i(insn_i),
        .dec_o(dec)
    );

    assign rn_val = regs_r[dec.rn];
    assign rm_val = regs_r[dec.rm];
    assign step = roa_pkg::size_bytes(dec.size);
    assign fire = insn_valid_i && insn_ready_o;
    assign is_mul = (dec.op == roa_pkg::ROA_MUL) || (dec.op == roa_pkg::ROA_MAC);
    assign is_mem = (dec.op == roa_pkg::ROA_LD_PCW) || (dec.op == roa_pkg::ROA_LD_PCL) ||
                    (dec.op == roa_pkg::ROA_LD_IND) || (dec.op == roa_pkg::ROA_LD_POST) ||
                    (dec.op == roa_pkg::ROA_ST_PRE) || (dec.op == roa_pkg::ROA_LD_IDX) ||
                    (dec.op == roa_pkg::ROA_AND_MEM);

    // Multiplier unit
    roa_multiplier u_mul (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .start_i(fire && is_mul),
        .acc_i(dec.op == roa_pkg::ROA_MAC),
        .a_i(rm_val[15:0]),
        .b_i(rn_val[15:0]),
        .acc_in_i(acc_o),
        .done_o(mul_done),
        .result_o(mul_res)
    );

    // Sequencer
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ROA_ST_EXEC:
            begin
                if (fire && is_mem)
                    state_nxt = ROA_ST_MEM;
                else if (fire && is_mul)
                    state_nxt = ROA_ST_MUL;
            end
            ROA_ST_MEM:
            begin
                if (mem_ack_i)
                    state_nxt = (cur_r.op == roa_pkg::ROA_AND_MEM) ? ROA_ST_RMW : ROA_ST_WB;
            end
            ROA_ST_RMW: state_nxt = mem_ack_i ? ROA_ST_EXEC : ROA_ST_RMW;
            ROA_ST_WB: state_nxt = ROA_ST_EXEC;
            ROA_ST_MUL: state_nxt = mul_done ? ROA_ST_EXEC : ROA_ST_MUL;
            default: state_nxt = ROA_ST_EXEC;
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            state_r <= ROA_ST_EXEC;
        else
            state_r <= state_nxt;
    end

    // Ready only while idle
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            insn_ready_o <= 1'b0;
        else
            insn_ready_o <= (state_nxt == ROA_ST_EXEC) && !(fire && (is_mem || is_mul));
    end

    // Latch every accepted instruction; the memory states read it back
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            cur_r <= '0;
        else if (fire)
            cur_r <= dec;
    end

    // Program counter with delay slot
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            pc_o <= roa_pkg::PC_RST;
            br_pend_r <= 1'b0;
            br_target_r <= roa_pkg::PC_RST;
        end
        else if (fire)
        begin
            if (br_pend_r)
            begin
                pc_o <= br_target_r;
                br_pend_r <= 1'b0;
            end
            else
                pc_o <= pc_o + 32'h0000_0002;
            if (dec.op == roa_pkg::ROA_BRA && !br_pend_r)
            begin
                br_pend_r <= 1'b1;
                br_target_r <= pc_o + 32'h0000_0004 + dec.imm;
            end
            else if ((dec.op == roa_pkg::ROA_BT && flag_o) ||
                     (dec.op == roa_pkg::ROA_BF && !flag_o))
                pc_o <= pc_o + 32'h0000_0004 + (dec.imm << 1);
        end
    end

    // Condition flag, only by compare and test
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_o <= 1'b0;
        else if (fire)
        begin
            case (dec.op)
                roa_pkg::ROA_CMPGE: flag_o <= $signed(rn_val) >= $signed(rm_val);
                roa_pkg::ROA_CMPEQ_IMM: flag_o <= regs_r[0] == dec.imm;
                roa_pkg::ROA_TST: flag_o <= (rn_val & rm_val) == 32'h0000_0000;
                roa_pkg::ROA_TST_IMM: flag_o <= (regs_r[0] & dec.imm) == 32'h0000_0000;
                default: flag_o <= flag_o;
            endcase
        end
    end

    // Memory requests and address arithmetic
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            mem_o <= '0;
        else if (fire && is_mem)
        begin
            mem_o.valid <= 1'b1;
            mem_o.size <= dec.size;
            mem_o.write <= (dec.op == roa_pkg::ROA_ST_PRE);
            mem_o.wdata <= rm_val;
            case (dec.op)
                roa_pkg::ROA_LD_PCW: mem_o.addr <= pc_o + 32'h0000_0004 + dec.imm;
                roa_pkg::ROA_LD_PCL:
                    mem_o.addr <= ((pc_o + 32'h0000_0004) & 32'hffff_fffc) + dec.imm;
                roa_pkg::ROA_ST_PRE: mem_o.addr <= rn_val - step;
                roa_pkg::ROA_LD_IDX: mem_o.addr <= regs_r[0] + rm_val;
                roa_pkg::ROA_AND_MEM: mem_o.addr <= regs_r[0];
                default: mem_o.addr <= rm_val;
            endcase
        end
        else if (state_r == ROA_ST_MEM && mem_ack_i && cur_r.op == roa_pkg::ROA_AND_MEM)
        begin
            mem_o.write <= 1'b1;
            mem_o.wdata <= mem_rdata_i & cur_r.imm;
        end
        else if (mem_ack_i)
            mem_o.valid <= 1'b0;
    end

    // Register file updates
    always_ff @(posedge ref_clk_i)
    begin
        if (fire)
        begin
            case (dec.op)
                roa_pkg::ROA_MOV_IMM: regs_r[dec.rn] <= dec.imm;
                roa_pkg::ROA_ADD_IMM: regs_r[dec.rn] <= rn_val + dec.imm;
                roa_pkg::ROA_ADD: regs_r[dec.rn] <= rn_val + rm_val;
                roa_pkg::ROA_MOV_REG: regs_r[dec.rn] <= rm_val;
                roa_pkg::ROA_AND_IMM: regs_r[0] <= regs_r[0] & dec.imm;
                roa_pkg::ROA_OR_IMM: regs_r[0] <= regs_r[0] | dec.imm;
                roa_pkg::ROA_XOR_IMM: regs_r[0] <= regs_r[0] ^ dec.imm;
                roa_pkg::ROA_LD_POST: regs_r[dec.rm] <= rm_val + step;
                roa_pkg::ROA_ST_PRE: regs_r[dec.rn] <= rn_val - step;
                default: ;
            endcase
        end
        else if (state_r == ROA_ST_MEM && mem_ack_i && !mem_o.write &&
                 cur_r.op != roa_pkg::ROA_AND_MEM)
            regs_r[cur_r.rn] <= roa_pkg::sext_mem(mem_rdata_i, cur_r.size);
    end

    // Accumulator and multiply result
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            acc_o <= roa_pkg::ACC_RST;
        else if (mul_done)
            acc_o <= mul_res;
    end

    // Software trap offset
    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            trap_o <= 1'b0;
            trap_offset_o <= 32'h0000_0000;
        end
        else
        begin
            trap_o <= fire && (dec.op == roa_pkg::ROA_TRAP);
            if (fire && dec.op == roa_pkg::ROA_TRAP)
                trap_offset_o <= dec.imm;
        end
    end
endmodule // roa_core

//--- dv/roa_core_properties.sv
`timescale 1ns/1ps
module roa_core_properties (
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] insn_i,
    input wire logic insn_valid_i,
    input wire logic mem_ack_i,
    input wire logic insn_ready_o,
    input wire logic [31:0] pc_o,
    input wire roa_pkg::roa_mem_s mem_o,
    input wire logic flag_o,
    input wire logic trap_o,
    input wire logic [31:0] trap_offset_o,
    input wire logic [41:0] acc_o
);
    localparam int MUL_D = roa_pkg::MUL_LAT + 1;
    localparam int MAC_D = roa_pkg::MAC_LAT + 1;
    logic take;
    logic take_mul;
    logic take_mac;

    // Accepted instruction and its multiply kinds
    assign take = insn_valid_i && insn_ready_o;
    assign take_mul = take && insn_i[15:12] == 4'h2 && insn_i[3:0] == 4'hF;
    assign take_mac = take && insn_i[15:12] == 4'h4 && insn_i[3:0] == 4'hF;

    // Single clock domain
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // Trap pulse, its cause and its vector offset
    a_trap_one_cycle: assert property (trap_o |=> !trap_o)
        else $error("trap pulse longer than one cycle");
    a_trap_cause: assert property (trap_o |-> $past(take && insn_i[15:8] == 8'hC3))
        else $error("trap without a trap instruction");
    a_trap_offset: assert property ($rose(trap_o) |->
        trap_offset_o == {22'h0, $past(insn_i[7:0]), 2'h0})
        else $error("trap offset not immediate times four");

    // Memory request holds and blocks new instructions
    a_req_held: assert property (mem_o.valid && !mem_ack_i |=> mem_o.valid && $stable(mem_o))
        else $error("memory request changed before ack");
    a_busy_refuses: assert property (mem_o.valid |-> !insn_ready_o)
        else $error("ready while memory pending");

    // Program counter
    a_pc_halfword: assert property (pc_o[0] == 1'b0)
        else $error("pc not on a 16-bit boundary");
    a_pc_on_take: assert property ($changed(pc_o) |-> $past(take))
        else $error("pc moved without an instruction");

    // Condition flag sources
    a_flag_sources: assert property ($changed(flag_o) |->
        $past(take && insn_i[15:12] inside {4'h2, 4'h3, 4'h8, 4'hC}))
        else $error("flag changed by an unexpected instruction");
    a_add_keeps_flag: assert property (take && insn_i[15:12] == 4'h7 |=> $stable(flag_o))
        else $error("add changed the flag");

    // Accumulator changes only at multiply latency
    a_acc_latency: assert property ($changed(acc_o) |->
        $past(take_mul, MUL_D) || $past(take_mac, MAC_D))
        else $error("accumulator changed at wrong time");

    // Main scenarios
    c_trap: cover property (trap_o);
    c_store: cover property (mem_o.valid && mem_o.write && mem_ack_i);
    c_flag: cover property ($rose(flag_o));
    c_acc: cover property ($changed(acc_o));
endmodule // roa_core_properties

bind roa_core roa_core_properties u_props (
    .ref_clk_i,
    .rst_n_i,
    .insn_i,
    .insn_valid_i,
    .mem_ack_i,
    .insn_ready_o,
    .pc_o,
    .mem_o,
    .flag_o,
    .trap_o,
    .trap_offset_o,
    .acc_o
);

//--- dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic [15:0] insn_i = 16'h0009;
    logic insn_valid_i = 1'b0;
    logic mem_ack_i = 1'b0;
    logic [31:0] mem_rdata_i;
    logic insn_ready_o;
    logic [31:0] pc_o;
    roa_pkg::roa_mem_s mem_o;
    logic flag_o;
    logic trap_o;
    logic [31:0] trap_offset_o;
    logic [41:0] acc_o;
    roa_pkg::roa_mem_s last_req;
    logic [31:0] rd_data = 32'h0000_0000;
    int wait_cnt = 0;
    int n_errors = 0;
    int n_checks = 0;

    // Core clock
    always #10 ref_clk_i = ~ref_clk_i;

    roa_core dut (
        .ref_clk_i,
        .rst_n_i,
        .insn_i,
        .insn_valid_i,
        .mem_ack_i,
        .mem_rdata_i,
        .insn_ready_o,
        .pc_o,
        .mem_o,
        .flag_o,
        .trap_o,
        .trap_offset_o,
        .acc_o
    );

    // Memory side: records and acks each request after a wait
    always @(posedge ref_clk_i)
    begin
        mem_ack_i <= 1'b0;
        if (mem_o.valid && !mem_ack_i)
        begin
            last_req <= mem_o;
            wait_cnt <= (wait_cnt == 2) ? 0 : wait_cnt + 1;
            if (wait_cnt == 2)
                mem_ack_i <= 1'b1;
        end
    end
    // Read data is garbage outside the ack
    assign mem_rdata_i = mem_ack_i ? rd_data : ~rd_data;

    // Compare helpers
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_word({31'h0, got}, {31'h0, exp}, what);
    endtask
    task automatic done(input string name);
        $display("%s test finished", name);
    endtask

    // Instruction issue, bounded waits
    task automatic wait_ready();
        int n;
        n = 0;
        do
        begin
            @(posedge ref_clk_i);
            n++;
        end
        while (insn_ready_o !== 1'b1 && n < 40);
        chk_bit(n < 40, 1'b1, "ready");
    endtask
    task automatic issue(input logic [15:0] w);
        @(posedge ref_clk_i);
        insn_i <= w;
        insn_valid_i <= 1'b1;
        wait_ready();
        insn_valid_i <= 1'b0;
        #1;
    endtask
    task automatic run(input logic [15:0] w);
        issue(w);
        wait_ready();
        #1;
    endtask
    // Long store of a register through R14 from 0x40
    task automatic store_chk(input logic [3:0] m, input logic [31:0] exp);
        run(16'hEE40);
        run({4'h2, 4'hE, m, 4'h6});
        chk_bit(last_req.write, 1'b1, "store dir");
        chk_word(last_req.addr, 32'h0000_003C, "store addr");
        chk_word(last_req.wdata, exp, "store data");
    endtask
    task automatic br_chk(input logic [15:0] w, input logic taken);
        logic [31:0] pc_s;
        pc_s = pc_o;
        run(w);
        chk_bit(pc_o !== pc_s + 32'h0000_0002, taken, "branch pc");
    endtask

    task automatic test_trap();
        logic [7:0] imm;
        for (int i = 0; i < 2; i++)
        begin
            imm = i ? 8'h01 : 8'hFF;
            issue({8'hC3, imm});
            chk_bit(trap_o, 1'b1, "trap");
            chk_word(trap_offset_o, {22'h0, imm, 2'h0}, "offset");
            @(posedge ref_clk_i);
            #1;
            chk_bit(trap_o, 1'b0, "trap end");
        end
        done("trap");
    endtask

    task automatic test_imm();
        run(16'hE180);
        store_chk(4'h1, 32'hFFFF_FF80);
        run(16'h71FF);
        store_chk(4'h1, 32'hFFFF_FF7F);
        run(16'hE0FE);
        run(16'h88FE);
        chk_bit(flag_o, 1'b1, "cmpeq");
        run(16'hE000);
        run(16'hCB80);
        store_chk(4'h0, 32'h0000_0080);
        run(16'hCAFF);
        store_chk(4'h0, 32'h0000_007F);
        run(16'hE0FF);
        run(16'hC981);
        store_chk(4'h0, 32'h0000_0081);
        run(16'hE080);
        run(16'h7080);
        run(16'h88FF);
        chk_bit(flag_o, 1'b0, "cmpeq ne");
        run(16'hC880);
        chk_bit(flag_o, 1'b1, "tst imm");
        done("immediate");
    endtask

    task automatic test_flag();
        run(16'hE105);
        run(16'hE203);
        run(16'h3213);
        chk_bit(flag_o, 1'b0, "ge false");
        run(16'h3123);
        chk_bit(flag_o, 1'b1, "ge true");
        run(16'h71FF);
        chk_bit(flag_o, 1'b1, "add imm");
        run(16'h312C);
        chk_bit(flag_o, 1'b1, "add reg");
        br_chk(16'h8904, 1'b1);
        br_chk(16'h8B04, 1'b0);
        run(16'hE3FF);
        run(16'h3313);
        chk_bit(flag_o, 1'b0, "ge signed");
        br_chk(16'h8904, 1'b0);
        br_chk(16'h8B04, 1'b1);
        run(16'hE000);
        run(16'h2008);
        chk_bit(flag_o, 1'b1, "tst zero");
        done("flag");
    endtask

    task automatic test_branch();
        logic [31:0] pc_s;
        run(16'hE000);
        run(16'h8801);
        pc_s = pc_o;
        issue(16'hA004);
        chk_word(pc_o, pc_s + 32'h0000_0002, "slot pc");
        chk_bit(flag_o, 1'b0, "before slot");
        issue(16'h8800);
        chk_bit(flag_o, 1'b1, "slot ran");
        chk_word(pc_o, pc_s + 32'h0000_000C, "jump");
        wait_ready();
        done("branch");
    endtask

    task automatic test_loads();
        rd_data = 32'h0000_8234;
        run(16'h9105);
        chk_word({29'h0, last_req.write, last_req.size}, 32'h0000_0001, "pcw");
        store_chk(4'h1, 32'hFFFF_8234);
        rd_data = 32'h1234_5678;
        run(16'hD102);
        chk_word({29'h0, last_req.write, last_req.size}, 32'h0000_0002, "pcl");
        run(16'h6312);
        chk_word(last_req.addr, 32'h1234_5678, "absolute");
        run(16'h6312);
        chk_word(last_req.addr, 32'h1234_5678, "indirect");
        rd_data = 32'h0000_1234;
        run(16'h9003);
        run(16'h041E);
        chk_word(last_req.addr, 32'h1234_68AC, "indexed");
        rd_data = 32'h0000_0080;
        run(16'h6510);
        store_chk(4'h5, 32'hFFFF_FF80);
        rd_data = 32'h0000_00F5;
        run(16'hE044);
        run(16'hCD3C);
        chk_word({29'h0, last_req.write, last_req.size}, 32'h0000_0004, "bit and");
        chk_word(last_req.addr, 32'h0000_0044, "bit addr");
        chk_word(last_req.wdata, 32'h0000_0034, "bit data");
        done("load");
    endtask

    task automatic test_step();
        run(16'hE520);
        run(16'hE740);
        run(16'hE8FD);
        for (int i = 0; i < 3; i++)
        begin
            run({12'h665, 4'(4 + i)});
            chk_word(last_req.addr, 32'h0000_0020 + 32'((1 << i) - 1), "post");
            run({12'h278, 4'(4 + i)});
            chk_word(last_req.addr, 32'h0000_0040 - 32'((2 << i) - 1), "pre");
            chk_word({29'h0, last_req.write, last_req.size}, 32'(4 + i), "pre size");
        end
        chk_word(last_req.wdata, 32'hFFFF_FFFD, "reg data");
        run(16'h6652);
        chk_word(last_req.addr, 32'h0000_0027, "post end");
        done("step");
    endtask

    task automatic test_mul();
        int n;
        logic [31:0] exp;
        run(16'hE1FD);
        run(16'hE207);
        for (int k = 0; k < 2; k++)
        begin
            exp = k ? 32'hFFFF_FFD6 : 32'hFFFF_FFEB;
            issue(k ? 16'h412F : 16'h221F);
            n = 0;
            while (acc_o[31:0] !== exp && n < 8)
            begin
                @(posedge ref_clk_i);
                #1;
                n++;
            end
            chk_word(acc_o[31:0], exp, "product");
            chk_word({22'h0, acc_o[41:32]}, 32'h0000_03FF, "acc high");
            chk_bit(n >= 1 + k && n <= 3, 1'b1, "mul cycles");
            wait_ready();
        end
        done("multiply");
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        repeat (5) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        repeat (2) @(posedge ref_clk_i);
        test_trap();
        test_imm();
        test_flag();
        test_branch();
        test_loads();
        test_step();
        test_mul();
        conclude();
    end

    // Watchdog
    initial
    begin
        repeat (20000) @(posedge ref_clk_i);
        n_errors++;
        $display("CHECK FAILED t=%0t watchdog", $time);
        conclude();
    end
endmodule // testbench
